//--- cmo_pkg.sv
// shared constants and types for the cache maintenance operation unit
package cmo_pkg;
	// instruction field positions
	localparam int OFF_LSB    = 0;   // signed offset field low bit
	localparam int OFF_W      = 9;   // offset width
	localparam int TGT_LSB    = 16;  // target cache field low bit
	localparam int OP_LSB     = 18;  // operation field low bit
	// target cache codes
	localparam logic [1:0] TGT_PRI_INST = 2'h0;
	localparam logic [1:0] TGT_PRI_DATA = 2'h1;
	localparam logic [1:0] TGT_TERTIARY = 2'h2;
	localparam logic [1:0] TGT_SECOND   = 2'h3;
	// operation codes
	localparam logic [2:0] OP_IDX_INV   = 3'h0;
	localparam logic [2:0] OP_LOAD_TAG  = 3'h1;
	// cache level selects (one bit per array port)
	localparam int LVL_N = 4;
	// unit states
	typedef enum logic [2:0] {
		CMO_IDLE, CMO_INNER, CMO_LOOK, CMO_WB, CMO_FENCE, CMO_DONE
	} cmo_state_t;
endpackage

//--- cmo_addr_gen.sv
// effective address and field extraction for a cache maintenance instruction
module cmo_addr_gen
	import cmo_pkg::*;
#(
	parameter int AW = 64
) (
	input  wire logic [31:0]   instr,
	input  wire logic [AW-1:0] base_val,
	output logic      [AW-1:0] eff_addr,
	output logic      [1:0]    tgt_sel,
	output logic      [2:0]    op_sel
);
	logic [OFF_W-1:0] off_raw; // raw signed offset
	assign off_raw = instr[OFF_LSB +: OFF_W];
	// sign extend and add; any alignment accepted, no alignment check [R19] [R20]
	assign eff_addr = base_val + {{(AW-OFF_W){off_raw[OFF_W-1]}}, off_raw};
	assign tgt_sel  = instr[TGT_LSB +: 2]; // [R04]
	assign op_sel   = instr[OP_LSB +: 3];  // [R05]
endmodule

//--- cmo_unit.sv
// cache maintenance operation unit: sequences index operations on the cache levels
//////////////////////////////////////////////////////////////////////////////////////
// Operation
// [R01] kernel-region load error optional; not raised
// [R02] watch match on maintenance optional; not raised
// [R03] completion waits like a memory barrier
// [R04] target cache from bits 17..16
// [R05] operation code from bits 20..18
// [R06] inclusive: inner level first, then outer
// [R07] software orders levels if hardware does not
// [R08] software adds barrier for non-inclusive writeback
// [R09] broadcast only coherent-attribute hit operations
// [R10] all affected levels share broadcast choice
// [R11] code 0 on instruction cache invalidates
// [R12] dirty write-back block written, then invalidated
// [R13] write-through or outer: code 0 invalidates
// [R14] software initialises with store-tag operation
// [R15] code 1 copies tag to holding registers
// [R16] code 1 also loads data holding registers
// [R17] tag read never raises cache error
// [R18] tag-read data aligned, low bits dropped
// [R19] address is base plus signed 9-bit offset
// [R20] any alignment accepted, no alignment error
// [R21] unsupported code or absent cache: no change
module cmo_unit
	import cmo_pkg::*;
#(
	parameter int   AW         = 64,          // address width
	parameter int   IDX_W      = 8,           // index width passed to the arrays
	parameter int   OFS_W      = 5,           // byte offset bits inside a block
	parameter int   TAG_W      = 40,          // tag width
	parameter int   DW         = 64,          // array read width
	parameter logic [3:0] LVL_PRESENT = 4'hf,  // which target caches exist
	parameter logic [3:0] LVL_WBACK   = 4'h2,  // which target caches are write-back
	parameter bit   INCLUSIVE  = 1'b1,        // hardware keeps inclusion
	parameter bit   HAS_DHOLD  = 1'b1         // data holding registers exist
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// pipeline side
	input  wire logic              req_valid,     // instruction issued
	output logic                   req_ready,     // unit can take one
	input  wire logic [31:0]       req_instr,
	input  wire logic [AW-1:0]     req_base,
	input  wire logic              req_coherent,  // coherent coherency_attribute
	output logic                   done_pulse,    // instruction completed
	output logic                   load_address_error_cause, // never raised here
	output logic                   cache_err,     // memory error seen during a non-tag op
	output logic                   globalized,    // broadcast taken for this op
	// array side, one select per level
	output logic [LVL_N-1:0]       arr_sel,
	output logic                   arr_rd,        // read tag/state/data at index
	output logic                   arr_inv,       // write invalid state at index
	output logic [IDX_W-1:0]       arr_idx,
	output logic [OFS_W-1:0]       arr_ofs,       // aligned byte index
	input  wire logic [TAG_W-1:0]  arr_tag,
	input  wire logic              arr_vld,
	input  wire logic              arr_dirty,
	input  wire logic [DW-1:0]     arr_data,
	// next memory level
	output logic                   wb_valid,
	input  wire logic              wb_ready,
	output logic [AW-1:0]          wb_addr,
	input  wire logic              mem_idle,      // all writes retired
	input  wire logic              mem_err,
	// system coprocessor holding registers
	output logic [31:0]            tag_hold_low,
	output logic [31:0]            tag_hold_high,
	output logic [31:0]            data_hold_low,
	output logic [31:0]            data_hold_high
);
	//////////////////////////////////////////////////////////////////////////////
	logic [AW-1:0]     ea;            // effective address
	logic [1:0]        tgt;           // decoded target
	logic [2:0]        opc;           // decoded operation
	cmo_state_t        state_reg;     // sequencer state
	logic [1:0]        tgt_reg;       // outer target
	logic [1:0]        cur_reg;       // level being worked
	logic [2:0]        op_reg;        // latched operation
	logic [AW-1:0]     ea_reg;        // latched address
	logic              glob_reg;      // broadcast choice for whole op
	logic              err_reg;       // error seen during op
	logic [TAG_W-1:0]  tag_reg;       // victim tag
	logic              rd_wait_reg;   // array read data present this cycle

	cmo_addr_gen #(.AW(AW)) u_addr (
		.instr    (req_instr),
		.base_val (req_base),
		.eff_addr (ea),
		.tgt_sel  (tgt),
		.op_sel   (opc)
	);

	// level to one-hot select
	function automatic logic [LVL_N-1:0] lvl_onehot(input logic [1:0] l);
		lvl_onehot = 4'h1 << l;
	endfunction

	// only index invalidate and load tag are built; others complete untouched
	function automatic logic op_supported(input logic [2:0] o, input logic [1:0] l);
		op_supported = LVL_PRESENT[l] && ((o == OP_IDX_INV) || (o == OP_LOAD_TAG));
	endfunction

	// the inner level for an outer target is the primary data cache
	function automatic logic needs_inner(input logic [1:0] l, input logic [2:0] o);
		needs_inner = INCLUSIVE && (o == OP_IDX_INV) && LVL_PRESENT[TGT_PRI_DATA]
			&& ((l == TGT_TERTIARY) || (l == TGT_SECOND));
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// handshake outputs
	assign req_ready = (state_reg == CMO_IDLE);
	// no kernel-region check and no watch trigger in this unit [R01] [R02]
	assign load_address_error_cause = 1'b0;
	assign arr_idx = ea_reg[OFS_W +: IDX_W];
	// aligned access: the low byte-index bits are dropped [R18]
	assign arr_ofs = {ea_reg[OFS_W-1:3], 3'h0};

	//////////////////////////////////////////////////////////////////////////////
	// sequencer: inner level, lookup, writeback, barrier-like completion
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= CMO_IDLE;
		end else begin
			case (state_reg)
				CMO_IDLE: begin
					if (req_valid) begin
						if (!op_supported(opc, tgt)) begin
							state_reg <= CMO_DONE; // no state change [R21]
						end else if (needs_inner(tgt, opc)) begin
							state_reg <= CMO_INNER; // inner first [R06]
						end else begin
							state_reg <= CMO_LOOK;
						end
					end
				end
				CMO_INNER, CMO_LOOK: begin
					if (rd_wait_reg) begin
						// dirty write-back block must go out first [R12]
						if (op_reg == OP_IDX_INV && arr_vld && arr_dirty
							&& LVL_WBACK[cur_reg]) begin
							state_reg <= CMO_WB;
						end else if (op_reg == OP_LOAD_TAG) begin
							state_reg <= CMO_FENCE;
						end else if (cur_reg != tgt_reg) begin
							state_reg <= CMO_LOOK; // inner done, go outer [R06]
						end else begin
							state_reg <= CMO_FENCE;
						end
					end
				end
				CMO_WB: begin
					if (wb_ready) begin
						state_reg <= (cur_reg != tgt_reg) ? CMO_LOOK : CMO_FENCE;
					end
				end
				CMO_FENCE: begin
					// complete only when writebacks have retired [R03]
					if (mem_idle) begin
						state_reg <= CMO_DONE;
					end
				end
				default: begin
					state_reg <= CMO_IDLE;
				end
			endcase
		end
	end

	// read is a two-cycle phase: issue, then sample the array answer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_wait_reg <= 1'b0;
		end else if ((state_reg == CMO_INNER || state_reg == CMO_LOOK) && !rd_wait_reg) begin
			rd_wait_reg <= 1'b1;
		end else begin
			rd_wait_reg <= 1'b0;
		end
	end

	// latch instruction fields and walk the current level
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tgt_reg  <= TGT_PRI_INST;
			cur_reg  <= TGT_PRI_INST;
			op_reg   <= OP_IDX_INV;
			ea_reg   <= '0;
			glob_reg <= 1'b0;
		end else if (state_reg == CMO_IDLE && req_valid) begin
			tgt_reg  <= tgt;
			op_reg   <= opc;
			ea_reg   <= ea;
			cur_reg  <= needs_inner(tgt, opc) ? TGT_PRI_DATA : tgt;
			// one broadcast choice for every level; index ops never broadcast [R09] [R10]
			glob_reg <= 1'b0 & req_coherent;
		end else if (state_reg == CMO_INNER && rd_wait_reg
			&& !(arr_vld && arr_dirty && LVL_WBACK[cur_reg])) begin
			cur_reg <= tgt_reg;
		end else if (state_reg == CMO_WB && wb_ready) begin
			cur_reg <= tgt_reg;
		end
	end

	// victim tag captured when the array answers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tag_reg <= '0;
		end else if (rd_wait_reg) begin
			tag_reg <= arr_tag;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// array strobes; invalidate after read, or in the same cycle the writeback is accepted
	always_comb begin
		arr_sel = '0;
		arr_rd  = 1'b0;
		arr_inv = 1'b0;
		if (state_reg == CMO_INNER || state_reg == CMO_LOOK) begin
			arr_sel = lvl_onehot(cur_reg);
			arr_rd  = !rd_wait_reg;
			// instruction cache, write-through or clean block: plain invalidate [R11] [R13]
			arr_inv = rd_wait_reg && op_reg == OP_IDX_INV
				&& !(arr_vld && arr_dirty && LVL_WBACK[cur_reg]);
		end else if (state_reg == CMO_WB) begin
			arr_sel = lvl_onehot(cur_reg);
			arr_inv = wb_ready; // [R12]
		end
	end

	// writeback to the address built from the tag and index [R12]
	assign wb_valid = (state_reg == CMO_WB);
	assign wb_addr  = AW'({tag_reg, arr_idx, {OFS_W{1'b0}}});

	//////////////////////////////////////////////////////////////////////////////
	// holding registers for the tag read [R15] [R16]
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tag_hold_low   <= '0;
			tag_hold_high  <= '0;
			data_hold_low  <= '0;
			data_hold_high <= '0;
		end else if (state_reg == CMO_LOOK && rd_wait_reg && op_reg == OP_LOAD_TAG) begin
			tag_hold_low  <= 32'(arr_tag);                            // [R15]
			tag_hold_high <= 32'({{64{1'b0}}, arr_tag} >> 32);        // [R15]
			if (HAS_DHOLD) begin
				data_hold_low  <= 32'(arr_data);                      // [R16]
				data_hold_high <= 32'({{64{1'b0}}, arr_data} >> 32);  // [R16]
			end
		end
	end

	// error flag: any memory error during a non-tag operation reports; tag read never does [R17]
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			err_reg <= 1'b0;
		end else if (state_reg == CMO_IDLE) begin
			err_reg <= 1'b0;
		end else if (mem_err && op_reg != OP_LOAD_TAG) begin
			err_reg <= 1'b1;
		end
	end

	// completion outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			done_pulse <= 1'b0;
			cache_err  <= 1'b0;
			globalized <= 1'b0;
		end else begin
			done_pulse <= (state_reg == CMO_DONE);
			cache_err  <= (state_reg == CMO_DONE) && err_reg; // [R17]
			globalized <= (state_reg == CMO_DONE) && glob_reg; // [R10]
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// checks
	no_load_address_error_cause_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R01]
		!load_address_error_cause) else $error("address error raised");
	fence_wait_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
		(state_reg == CMO_FENCE && !mem_idle) |=> state_reg == CMO_FENCE)
		else $error("completed before memory idle");
	inner_first_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
		(state_reg == CMO_INNER && arr_rd) |-> arr_sel == 4'h2)
		else $error("inner level not primary data");
	no_glob_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R09]
		!globalized) else $error("index op broadcast");
	wb_then_inv_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
		(wb_valid && !wb_ready) |-> !arr_inv) else $error("invalidated before writeback");
	tag_no_err_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
		(done_pulse && op_reg == OP_LOAD_TAG) |-> !cache_err)
		else $error("tag read raised error");
	tag_copy_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
		(state_reg == CMO_LOOK && rd_wait_reg && op_reg == OP_LOAD_TAG)
		|=> tag_hold_low == 32'($past(arr_tag))) else $error("tag not copied");
	unsup_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R21]
		(req_ready && req_valid && !op_supported(opc, tgt))
		|=> state_reg == CMO_DONE ##1 (state_reg == CMO_IDLE && done_pulse))
		else $error("unsupported op touched arrays");
endmodule

//--- cmo_array_model.sv
// behavioural cache arrays and next memory level facing the maintenance unit
module cmo_array_model #(
	parameter int IDX_W    = 4,  // index width
	parameter int WB_LAT   = 3,  // cycles before a writeback is taken
	parameter int IDLE_LAT = 4   // cycles the taken write drains
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [3:0]       arr_sel,
	input  wire logic             arr_rd,
	input  wire logic             arr_inv,
	input  wire logic [IDX_W-1:0] arr_idx,
	output logic      [39:0]      arr_tag,
	output logic                  arr_vld,
	output logic                  arr_dirty,
	output logic      [63:0]      arr_data,
	input  wire logic             wb_valid,
	output logic                  wb_ready,
	output logic                  mem_idle,
	output logic                  mem_err,
	input  wire logic             fail_wb    // scenario asks for a bus error
);
	timeunit 1ns;
	timeprecision 1ps;
	logic vld_reg [4][2**IDX_W];  // valid bit per level and index
	logic dty_reg [4][2**IDX_W];  // dirty bit per level and index
	int   wait_reg;               // cycles the writeback has waited
	int   busy_reg;               // drain cycles left
	////////////////////////////////////////////////////////////
	// all lines valid at reset, odd data lines dirty: preloaded as a store-tag pass would
	always_ff @(posedge mclk) begin
		for (int l = 0; l < 4; l++) begin
			for (int i = 0; i < 2**IDX_W; i++) begin
				if (!rst_n) begin
					vld_reg[l][i] <= 1'h1;
					dty_reg[l][i] <= (l == 1) && i[0];
				end else if (arr_inv && arr_sel[l] && i == int'(arr_idx)) begin
					vld_reg[l][i] <= 1'h0;
					dty_reg[l][i] <= 1'h0;
				end
			end
		end
	end
	// answer one cycle after a read; otherwise churn so stale data is never trusted
	always_ff @(posedge mclk) begin
		arr_tag   <= ~arr_tag;
		arr_vld   <= ~arr_vld;
		arr_dirty <= ~arr_dirty;
		arr_data  <= ~arr_data;
		for (int l = 0; l < 4; l++) begin
			if (!rst_n) begin
				arr_tag   <= 40'h0;
				arr_vld   <= 1'h0;
				arr_dirty <= 1'h0;
				arr_data  <= 64'h0;
			end else if (arr_rd && arr_sel[l]) begin
				arr_tag   <= {8'h5a, 20'h0, 4'(l), 8'(arr_idx)};
				arr_vld   <= vld_reg[l][arr_idx];
				arr_dirty <= dty_reg[l][arr_idx];
				arr_data  <= {24'h0, 8'h5a, 20'h0, 4'(l), 8'(arr_idx)};
			end
		end
	end
	// slow acceptance, then the write drains before memory reports idle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wait_reg <= 0;
			busy_reg <= 0;
			wb_ready <= 1'h0;
		end else begin
			wb_ready <= wb_valid && !wb_ready && wait_reg == WB_LAT - 1;
			wait_reg <= (wb_valid && !wb_ready) ? wait_reg + 1 : 0;
			if (wb_valid && wb_ready)
				busy_reg <= IDLE_LAT;
			else if (busy_reg != 0)
				busy_reg <= busy_reg - 1;
		end
	end
	assign mem_idle = busy_reg == 0;
	// error while draining, or on an array read so a tag read sees one too
	assign mem_err  = fail_wb && (busy_reg != 0 || arr_rd);
endmodule

//--- cmo_unit_tb.sv
// self-checking testbench for the cache maintenance operation unit
module cmo_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cmo_pkg::*;
	logic        mclk, rst_n, req_valid, req_ready, req_coherent, done_pulse, lae, cache_err;
	logic        globalized, arr_rd, arr_inv, arr_vld, arr_dirty, wb_valid, wb_ready;
	logic        mem_idle, mem_err, fail_wb;
	logic [31:0] req_instr, tag_hold_low, tag_hold_high, data_hold_low, data_hold_high;
	logic [63:0] req_base, arr_data, wb_addr, wb_a;
	logic [3:0]  arr_sel, arr_idx, rd_sel, rd_idx, inv_q[$];
	logic [4:0]  arr_ofs, rd_ofs;
	logic [39:0] arr_tag;
	int          n_mismatch, n_tests, cyc, lat, wb_n, wb_cyc;
	cmo_unit #(.IDX_W(4)) i_cmo_unit (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_instr(req_instr), .req_base(req_base),
		.req_coherent(req_coherent), .done_pulse(done_pulse), .load_address_error_cause(lae),
		.cache_err(cache_err), .globalized(globalized), .arr_sel(arr_sel), .arr_rd(arr_rd),
		.arr_inv(arr_inv), .arr_idx(arr_idx), .arr_ofs(arr_ofs), .arr_tag(arr_tag),
		.arr_vld(arr_vld), .arr_dirty(arr_dirty), .arr_data(arr_data), .wb_valid(wb_valid),
		.wb_ready(wb_ready), .wb_addr(wb_addr), .mem_idle(mem_idle), .mem_err(mem_err),
		.tag_hold_low(tag_hold_low), .tag_hold_high(tag_hold_high),
		.data_hold_low(data_hold_low), .data_hold_high(data_hold_high));
	cmo_array_model i_cmo_array_model (.mclk(mclk), .rst_n(rst_n), .arr_sel(arr_sel),
		.arr_rd(arr_rd), .arr_inv(arr_inv), .arr_idx(arr_idx), .arr_tag(arr_tag),
		.arr_vld(arr_vld), .arr_dirty(arr_dirty), .arr_data(arr_data), .wb_valid(wb_valid),
		.wb_ready(wb_ready), .mem_idle(mem_idle), .mem_err(mem_err), .fail_wb(fail_wb));
	always #10 mclk = ~mclk;
	////////////////////////////////////////////////////////////
	// watch ports mid-cycle where they are settled; also cut a hang short
	always @(negedge mclk) begin
		cyc++;
		if (arr_rd === 1'h1) begin
			rd_sel = arr_sel;
			rd_idx = arr_idx;
			rd_ofs = arr_ofs;
		end
		if (arr_inv === 1'h1)
			inv_q.push_back(arr_sel);
		if (wb_valid === 1'h1 && wb_ready === 1'h1) begin
			wb_n++;
			wb_a   = wb_addr;
			wb_cyc = cyc;
		end
		if (cyc == 4000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one request, offset -3 from base so the address ends at byte 13 of the line
	task automatic issue(input logic [2:0] op, input logic [1:0] tgt, input logic [3:0] idx,
		input logic coh, input logic err);
		@(posedge mclk);
		req_valid    <= 1'h1;
		req_instr    <= {11'h0, op, tgt, 7'h0, 9'h1fd};
		req_base     <= 64'h1000_0010 | {55'h0, idx, 5'h0};
		req_coherent <= coh;
		fail_wb      <= err;
		@(negedge mclk);
		while (req_ready !== 1'h1) @(negedge mclk);
		@(posedge mclk);
		req_valid <= 1'h0;
		inv_q.delete();
		lat = 0;
		do begin
			@(negedge mclk);
			lat++;
		end while (done_pulse !== 1'h1);
		chk(lae, 1'h0);
		chk(globalized, 1'h0);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_tag_read;
		logic [39:0] tag;
		for (int t = 0; t < 4; t++) begin
			tag = {8'h5a, 20'h0, 4'(t), 8'h09};
			// odd targets also see a bus error, which a tag read must ignore
			issue(OP_LOAD_TAG, 2'(t), 4'h9, 1'h1, 1'(t));
			chk(lat, 5);
			chk(rd_sel, 64'(1 << t));
			chk(rd_idx, 4'h9);
			chk(rd_ofs, 5'h08);
			chk(tag_hold_low, tag[31:0]);
			chk(tag_hold_high, tag[39:32]);
			chk(data_hold_low, tag[31:0]);
			chk(data_hold_high, tag[39:32]);
			chk(cache_err, 1'h0);
			chk(inv_q.size(), 0);
		end
		$display("tag read done");
	endtask
	task automatic t_invalidate;
		issue(OP_IDX_INV, TGT_PRI_INST, 4'h3, 1'h0, 1'h0);
		chk(i_cmo_array_model.vld_reg[0][3], 1'h0);
		chk(wb_n, 0);
		issue(OP_IDX_INV, TGT_PRI_DATA, 4'h2, 1'h0, 1'h0);
		chk(wb_n, 0);
		chk(i_cmo_array_model.vld_reg[1][2], 1'h0);
		issue(OP_IDX_INV, TGT_PRI_DATA, 4'h9, 1'h0, 1'h0);
		chk(wb_n, 1);
		chk(wb_a, {15'h0, 8'h5a, 20'h0, 4'h1, 8'h09, 4'h9, 5'h0});
		chk(i_cmo_array_model.vld_reg[1][9], 1'h0);
		chk(cyc - wb_cyc >= 4, 1'h1);
		issue(OP_IDX_INV, TGT_PRI_DATA, 4'hb, 1'h0, 1'h1);
		chk(cache_err, 1'h1);
		$display("invalidate done");
	endtask
	task automatic t_outer;
		issue(OP_IDX_INV, TGT_SECOND, 4'h5, 1'h1, 1'h0);
		chk(inv_q[0], 4'h2);
		chk(inv_q[inv_q.size() - 1], 4'h8);
		chk(i_cmo_array_model.vld_reg[1][5], 1'h0);
		chk(i_cmo_array_model.vld_reg[3][5], 1'h0);
		issue(OP_IDX_INV, TGT_TERTIARY, 4'h6, 1'h1, 1'h0);
		chk(i_cmo_array_model.vld_reg[2][6], 1'h0);
		// software order: inner level, wait for its writeback, then the outer level
		issue(OP_IDX_INV, TGT_PRI_DATA, 4'h7, 1'h0, 1'h0);
		chk(wb_n, 4);
		issue(OP_IDX_INV, TGT_SECOND, 4'h7, 1'h0, 1'h0);
		chk(wb_n, 4);
		chk(i_cmo_array_model.vld_reg[3][7], 1'h0);
		$display("outer done");
	endtask
	task automatic t_unsupported;
		for (int op = 2; op < 8; op++) begin
			issue(3'(op), TGT_PRI_DATA, 4'h4, 1'h0, 1'h0);
			chk(lat, 2);
			chk(inv_q.size(), 0);
			chk(i_cmo_array_model.vld_reg[1][4], 1'h1);
		end
		$display("unsupported done");
	endtask
	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{mclk, rst_n, req_valid, req_coherent, fail_wb} = 5'h0;
		req_instr = 32'h0;
		req_base  = 64'h0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'h1;
		t_tag_read();
		t_invalidate();
		t_outer();
		t_unsupported();
		results();
	end
endmodule
